// ==== hdl/gdc_pkg.sv ====
package gdc_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int NUM_PORTS   = 12;
   localparam int PORT_BITS   = 4;
   localparam int PINS        = NUM_PORTS * PORT_BITS;
   localparam int FIRST_GROUP = 8;

   // Port order: 0A 0B 0C 1D 2A 2B 2C 2D 3A 3B 3C 3D
   localparam int PORT_WIDTH [NUM_PORTS] = '{4, 4, 4, 4, 3, 4, 4, 3, 4, 4, 4, 4};

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_PORT_ZERO_A_DIRECTION_SELECT = 8'h6F;
   localparam logic [7:0] IDX_PORT_ZERO_B_DIRECTION_SELECT = 8'h6E;
   localparam logic [7:0] IDX_PORT_ZERO_C_DIRECTION_SELECT = 8'h6D;
   localparam logic [7:0] IDX_PORT_ONE_D_DIRECTION_SELECT  = 8'h6C;
   localparam logic [7:0] IDX_PORT_TWO_A_DIRECTION_SELECT  = 8'h6B;
   localparam logic [7:0] IDX_PORT_TWO_B_DIRECTION_SELECT  = 8'h6A;
   localparam logic [7:0] IDX_PORT_TWO_C_DIRECTION_SELECT  = 8'h69;
   localparam logic [7:0] IDX_PORT_TWO_D_DIRECTION_SELECT  = 8'h68;
   localparam logic [7:0] IDX_GROUP_DIRECTION_SELECT       = 8'h67;
   localparam logic [7:0] IDX_PORT_DATA_BASE               = 8'h40;
   localparam logic [7:0] IDX_STATUS                       = 8'h50;

   localparam logic [7:0] IDX_DIRECTION [FIRST_GROUP] = '{
      IDX_PORT_ZERO_A_DIRECTION_SELECT, IDX_PORT_ZERO_B_DIRECTION_SELECT,
      IDX_PORT_ZERO_C_DIRECTION_SELECT, IDX_PORT_ONE_D_DIRECTION_SELECT,
      IDX_PORT_TWO_A_DIRECTION_SELECT,  IDX_PORT_TWO_B_DIRECTION_SELECT,
      IDX_PORT_TWO_C_DIRECTION_SELECT,  IDX_PORT_TWO_D_DIRECTION_SELECT};

   // ------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------
   localparam logic [3:0]  DIRECTION_RESET = 4'h0;
   localparam logic [3:0]  LATCH_RESET     = 4'h0;
   localparam logic        DIR_INPUT       = 1'b0;
   localparam logic        DIR_OUTPUT      = 1'b1;
   localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

   function automatic logic [3:0] width_mask(input int width);
      width_mask = 4'(({{PORT_BITS{1'b0}}, {PORT_BITS{1'b1}}} >> (PORT_BITS - width)));
   endfunction : width_mask

endpackage : gdc_pkg

// ==== hdl/gdc_port_cell.sv ====
`timescale 1ns/1ps
module gdc_port_cell #(
   parameter int WIDTH = 4,
   parameter bit GROUP = 1'b0
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Direction control
   input  wire logic       clear_dir,
   input  wire logic       dir_wr,
   input  wire logic [3:0] dir_wdata,
   // Output latch
   input  wire logic       data_wr,
   input  wire logic [3:0] data_wdata,
   // Pins
   input  wire logic       input_stop,
   input  wire logic [3:0] pin_in,
   output logic      [3:0] pin_out,
   output logic      [3:0] pin_oe,
   // Readback
   output logic      [3:0] dir,
   output logic      [3:0] data_rd
);

   localparam logic [3:0] MASK = gdc_pkg::width_mask(WIDTH);

   logic [3:0] latch;
   wire  [3:0] dir_value  = GROUP ? {4{dir_wdata[0]}} : dir_wdata;
   wire  [3:0] next_dir   = clear_dir ? gdc_pkg::DIRECTION_RESET
                          : (dir_wr ? (dir_value & MASK) : dir);
   // Input-mode buffers are shut while stopped, so floating pins cannot draw current
   wire  [3:0] input_gate = input_stop ? dir : 4'hF;
   wire  [3:0] next_data  = pin_in & input_gate & MASK;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir     <= gdc_pkg::DIRECTION_RESET;
         latch   <= gdc_pkg::LATCH_RESET;
         pin_out <= gdc_pkg::LATCH_RESET;
         pin_oe  <= gdc_pkg::DIRECTION_RESET;
         data_rd <= gdc_pkg::LATCH_RESET;
      end else if (clk_en) begin
         dir     <= next_dir;
         if (data_wr) begin
            latch <= data_wdata & MASK;
         end
         pin_out <= latch & MASK;
         pin_oe  <= next_dir;
         data_rd <= next_data;
      end
   end

endmodule : gdc_port_cell

// ==== hdl/gdc_top.sv ====
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Ports 0A,0B,0C,1D,2A,2B,2C,2D set direction pin by pin.
// - Ports 3A..3D switch direction for all four pins together.
// - Port write updates output latch; port read returns pin levels.
// - Direction bit 0 makes the pin input, 1 makes it output.
// - One per-pin direction register per bit port, one grouped register.
// - Ports 2A and 2D implement only bits 2 to 0.
// - Clock stop asserts input stop, shutting input buffers of floating pins.
module gdc_top #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, enable
   input  wire logic                       SYS_CLK,
   input  wire logic                       RST,
   input  wire logic                       CLK_EN,
   // Core events
   input  wire logic                       WATCHDOG_STACK_RESET,
   input  wire logic                       CLOCK_STOP,
   // Wishbone slave
   input  wire logic [ADDR_W-1:0]          WB_ADR_I,
   input  wire logic [31:0]                WB_DAT_I,
   input  wire logic [3:0]                 WB_SEL_I,
   input  wire logic                       WB_WE_I,
   input  wire logic                       WB_CYC_I,
   input  wire logic                       WB_STB_I,
   output logic      [31:0]                WB_DAT_O,
   output logic                            WB_ACK_O,
   // Pins
   input  wire logic [gdc_pkg::PINS-1:0]   PIN_IN,
   output logic      [gdc_pkg::PINS-1:0]   PIN_OUT,
   output logic      [gdc_pkg::PINS-1:0]   PIN_OE,
   output logic                            INPUT_STOP
);

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   localparam int ADR_HI = (ADDR_W > 10) ? 9 : ADDR_W - 1;

   wire        request   = WB_CYC_I & WB_STB_I;
   // Writes land on the edge at which the master samples ack
   wire        write_now = request & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
   wire        read_now  = request & ~WB_ACK_O;
   wire [7:0]  word_idx  = 8'(WB_ADR_I[ADR_HI:2]);
   wire [3:0]  wdata     = WB_DAT_I[3:0];

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire [gdc_pkg::NUM_PORTS-1:0] hit_dir;
   wire [gdc_pkg::NUM_PORTS-1:0] hit_data;
   wire [gdc_pkg::NUM_PORTS-1:0] dir_wr;
   wire [gdc_pkg::NUM_PORTS-1:0] data_wr;
   wire [3:0]                    dir_wdata [gdc_pkg::NUM_PORTS];
   wire [3:0]                    dir_rd    [gdc_pkg::NUM_PORTS];
   wire [3:0]                    data_rd   [gdc_pkg::NUM_PORTS];
   wire                          hit_group  = (word_idx == gdc_pkg::IDX_GROUP_DIRECTION_SELECT);
   wire                          hit_status = (word_idx == gdc_pkg::IDX_STATUS);

   genvar p;
   generate
      for (p = 0; p < gdc_pkg::NUM_PORTS; p = p + 1) begin : g_port
         if (p < gdc_pkg::FIRST_GROUP) begin : g_bit
            assign hit_dir[p]   = (word_idx == gdc_pkg::IDX_DIRECTION[p]);
            assign dir_wdata[p] = wdata;
         end else begin : g_grp
            assign hit_dir[p]   = hit_group;
            assign dir_wdata[p] = {4{wdata[p - gdc_pkg::FIRST_GROUP]}};
         end
         assign hit_data[p] = (word_idx == 8'(gdc_pkg::IDX_PORT_DATA_BASE + 8'(p)));
         assign dir_wr[p]   = write_now & hit_dir[p];
         assign data_wr[p]  = write_now & hit_data[p];

         gdc_port_cell #(
            .WIDTH (gdc_pkg::PORT_WIDTH[p]),
            .GROUP (p >= gdc_pkg::FIRST_GROUP)
         ) u_cell (
            .clk        (SYS_CLK),
            .rst        (RST),
            .clk_en     (CLK_EN),
            .clear_dir  (WATCHDOG_STACK_RESET),
            .dir_wr     (dir_wr[p]),
            .dir_wdata  (dir_wdata[p]),
            .data_wr    (data_wr[p]),
            .data_wdata (wdata),
            .input_stop (INPUT_STOP),
            .pin_in     (PIN_IN[p*4 +: 4]),
            .pin_out    (PIN_OUT[p*4 +: 4]),
            .pin_oe     (PIN_OE[p*4 +: 4]),
            .dir        (dir_rd[p]),
            .data_rd    (data_rd[p])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Read selection
   // ------------------------------------------------------------
   function automatic logic [3:0] pick(input logic [gdc_pkg::NUM_PORTS-1:0] hit,
                                       input logic [3:0] src [gdc_pkg::NUM_PORTS]);
      logic [3:0] acc;
      acc = 4'h0;
      for (int i = 0; i < gdc_pkg::NUM_PORTS; i++) begin
         if (hit[i]) begin
            acc = acc | src[i];
         end
      end
      pick = acc;
   endfunction : pick

   wire [gdc_pkg::NUM_PORTS-1:0] hit_dir_bit = hit_dir & {{4{1'b0}}, {gdc_pkg::FIRST_GROUP{1'b1}}};
   wire [3:0] group_rd   = {dir_rd[11][0], dir_rd[10][0], dir_rd[9][0], dir_rd[8][0]};
   wire [3:0] status_rd  = {3'h0, INPUT_STOP};
   wire       mapped     = (|hit_dir_bit) | hit_group | (|hit_data) | hit_status;
   wire [3:0] sel_nibble = pick(hit_dir_bit, dir_rd) | pick(hit_data, data_rd)
                         | (hit_group ? group_rd : 4'h0) | (hit_status ? status_rd : 4'h0);
   wire [31:0] next_rdata = mapped ? {28'h0000000, sel_nibble} : gdc_pkg::UNMAPPED_READ;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         WB_ACK_O   <= 1'b0;
         WB_DAT_O   <= gdc_pkg::UNMAPPED_READ;
         INPUT_STOP <= 1'b0;
      end else if (CLK_EN) begin
         WB_ACK_O   <= read_now;
         if (read_now) begin
            WB_DAT_O <= next_rdata;
         end
         INPUT_STOP <= CLOCK_STOP;
      end
   end

endmodule : gdc_top

// ==== test/gdc_asserts.sv ====
`timescale 1ns/1ps
module gdc_asserts #(
   parameter int ADDR_W = 12
) (
   // Clock, reset, core events
   input wire logic              SYS_CLK,
   input wire logic              RST,
   input wire logic              CLK_EN,
   input wire logic              WATCHDOG_STACK_RESET,
   input wire logic              CLOCK_STOP,
   // Register bus
   input wire logic [ADDR_W-1:0] WB_ADR_I,
   input wire logic [31:0]       WB_DAT_I,
   input wire logic [3:0]        WB_SEL_I,
   input wire logic              WB_WE_I,
   input wire logic              WB_CYC_I,
   input wire logic              WB_STB_I,
   input wire logic [31:0]       WB_DAT_O,
   input wire logic              WB_ACK_O,
   // Pins
   input wire logic [47:0]       PIN_IN,
   input wire logic [47:0]       PIN_OUT,
   input wire logic [47:0]       PIN_OE,
   input wire logic              INPUT_STOP
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic       wr;
   logic [7:0] idx;
   // Watchdog clear wins, so a write in that cycle is left out; a frozen edge writes nothing
   assign wr  = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && WB_ACK_O && !WATCHDOG_STACK_RESET
                && CLK_EN;
   assign idx = WB_ADR_I[9:2];
   ack_one_pulse_a: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O) else $error("ack too long");
   ack_after_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O)
      else $error("no ack");
   stop_follows_a: assert property (CLK_EN |=> INPUT_STOP == $past(CLOCK_STOP)) else $error("stop lag");
   trim_bits_zero_a: assert property (!(PIN_OE[19] || PIN_OUT[19] || PIN_OE[31] || PIN_OUT[31]))
      else $error("missing pin driven");
   group_nibble_a: assert property (PIN_OE[47:32] == {{4{PIN_OE[44]}}, {4{PIN_OE[40]}},
      {4{PIN_OE[36]}}, {4{PIN_OE[32]}}}) else $error("group split");
   dir_write_oe_a: assert property (wr && idx == 8'h6F |=> PIN_OE[3:0] == $past(WB_DAT_I[3:0]))
      else $error("direction not applied");
   wdt_clear_dir_a: assert property (WATCHDOG_STACK_RESET && CLK_EN |=> PIN_OE == 48'h0)
      else $error("direction kept");
   latch_to_pin_a: assert property ((wr && idx == 8'h40) ##1 CLK_EN |=> PIN_OUT[3:0] == $past(WB_DAT_I[3:0], 2))
      else $error("latch not driven");
   read_upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:4] == 28'h0) else $error("high bits set");
   cover property (wr && idx == 8'h67);
   cover property (WATCHDOG_STACK_RESET);
   cover property (INPUT_STOP && WB_ACK_O);
   cover property (!CLK_EN && WB_CYC_I && WB_STB_I);
endmodule : gdc_asserts

bind gdc_top gdc_asserts #(.ADDR_W(ADDR_W)) i_gdc_asserts (.*);

// ==== test/gdc_pins_model.sv ====
`timescale 1ns/1ps
module gdc_pins_model (
   // Pin sides
   input  wire logic [47:0] pin_out,
   input  wire logic [47:0] pin_oe,
   input  wire logic [47:0] board,
   output logic      [47:0] pin_in
);
   // Released pins show a board level that the bench keeps changing
   assign pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
endmodule : gdc_pins_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic clk, rst, ce, wdr, cstop, cyc, stb, wen, ack, istop;
   logic [11:0] adr;
   logic [31:0] dat, rdat, r;
   logic [3:0]  sel, gm, dm[8], lm[12];
   logic [47:0] board, pin_in, pin_out, pin_oe;
   int          bad_count = 0, num_checks = 0;
   logic [7:0]  tbl[16] = '{8'h6F, 8'h6E, 8'h6D, 8'h6C, 8'h6B, 8'h6A, 8'h69, 8'h68, 8'h67,
                            8'h40, 8'h44, 8'h47, 8'h48, 8'h4B, 8'h50, 8'h7C};
   gdc_top i_gdc_top (.SYS_CLK(clk), .RST(rst), .CLK_EN(ce), .WATCHDOG_STACK_RESET(wdr), .CLOCK_STOP(cstop),
      .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_WE_I(wen), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .INPUT_STOP(istop));
   gdc_pins_model i_gdc_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .pin_in(pin_in));
   always #2 clk = ~clk;
   // ----
   // Reference model
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [3:0] mk(input int p);
      return (p == 4 || p == 7) ? 4'h7 : 4'hF;
   endfunction : mk
   function automatic logic [3:0] dirof(input int p);
      return (p < 8) ? dm[p] : {4{gm[p-8]}};
   endfunction : dirof
   function automatic logic [3:0] expv(input logic [7:0] ix);
      int p;
      p = ix - 8'h40;
      if (ix >= 8'h68 && ix <= 8'h6F) return dm[8'h6F - ix];
      if (ix == 8'h67) return gm;
      if (ix == 8'h50) return {3'h0, cstop};
      if (p < 0 || p > 11) return 4'h0;
      // Stopped inputs read low
      return ((lm[p] & dirof(p)) | (board[4*p+:4] & ~dirof(p) & {4{!cstop}})) & mk(p);
   endfunction : expv
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic wb(input logic [7:0] ix, input logic we, input logic [3:0] d, input logic s,
                     output logic [31:0] q);
      int n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= we;
      adr <= {2'h0, ix, 2'h0};
      dat <= {28'h0, d};
      sel <= {3'h0, s};
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) begin
         bad_count++;
         end_sim();
      end
      q = rdat;
      if (we && s && ix >= 8'h68 && ix <= 8'h6F) dm[8'h6F - ix] = d & mk(8'h6F - ix);
      if (we && s && ix == 8'h67) gm = d;
      if (we && s && ix >= 8'h40 && ix <= 8'h4B) lm[ix - 8'h40] = d & mk(ix - 8'h40);
      cyc <= 1'b0; stb <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wb
   task automatic pins;
      logic [47:0] eo, ou;
      for (int p = 0; p < 12; p++) begin
         eo[4*p+:4] = dirof(p) & mk(p);
         ou[4*p+:4] = lm[p];
      end
      chk(pin_oe, eo);
      chk(pin_out, ou);
      chk({47'h0, istop}, {47'h0, cstop});
   endtask : pins
   task automatic sweep(input int t);
      logic [31:0] q;
      foreach (tbl[k]) begin
         wb(tbl[k], 1'b0, 4'h0, 1'b0, q);
         chk({16'h0, q}, {44'h0, expv(tbl[k])});
      end
      pins();
      $display("test %0d done", t);
   endtask : sweep
   task automatic clear(input bit all);
      gm = 4'h0;
      for (int p = 0; p < 12; p++) begin
         if (p < 8) dm[p] = 4'h0;
         if (all) lm[p] = 4'h0;
      end
   endtask : clear
   // ----
   // Sequence
   // ----
   initial begin
      logic [31:0] q;
      clk = 0;
      rst = 1;
      ce = 1;
      wdr = 0;
      cstop = 0;
      cyc = 0;
      stb = 0;
      wen = 0;
      adr = 0;
      dat = 0;
      sel = 0;
      board = 0;
      r = 32'h51B8433F;
      clear(1);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sweep(1);
      for (int i = 0; i < 60; i++) begin
         r = lfsr(r);
         board <= {r, r[31:16]};
         wb(tbl[r[3:0]], 1'b1, r[7:4], r[8] | r[9], q);
         wb(tbl[r[3:0]], 1'b0, 4'h0, 1'b0, q);
         chk({16'h0, q}, {44'h0, expv(tbl[r[3:0]])});
         pins();
      end
      sweep(2);
      // Enable low: the request waits, no ack and no direction change until it returns
      ce <= 1'b0;
      fork
         wb(8'h6F, 1'b1, 4'hA, 1'b1, q);
         begin
            repeat (4) @(posedge clk);
            chk({47'h0, ack}, 48'h0);
            pins();
            ce <= 1'b1;
         end
      join
      pins();
      $display("test clock enable done");
      wdr <= 1'b1;
      @(posedge clk);
      wdr <= 1'b0;
      clear(0);
      @(posedge clk);
      sweep(3);
      for (int i = 0; i < 13; i++) wb(tbl[i], 1'b1, 4'h5 + i[3:0], 1'b1, q);
      cstop <= 1'b1;
      repeat (2) @(posedge clk);
      sweep(4);
      cstop <= 1'b0;
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      clear(1);
      @(posedge clk);
      sweep(5);
      end_sim();
   end
endmodule : tb
